// *** rtl/tx_ptp_qual_pkg.sv ***
// Constants shared by the transmit PTP timestamp qualifier and its helpers.
// Assumes a 12-bit APB byte address and untagged Ethernet frames.
package tx_ptp_qual_pkg;
    localparam int          APB_AW        = 12;
    localparam int          APB_DW        = 32;
    // Register byte addresses.
    localparam logic [11:0] ADDR_CMD      = 12'h000;
    localparam logic [11:0] ADDR_BANK     = 12'h040;
    localparam logic [11:0] ADDR_PARSE    = 12'h158;
    localparam logic [11:0] ADDR_QUAL     = 12'h15c;
    localparam logic [11:0] ADDR_EG_SEC   = 12'h16c;
    localparam logic [11:0] ADDR_EG_NS    = 12'h170;
    localparam logic [11:0] ADDR_HDR      = 12'h174;
    localparam logic [11:0] ADDR_STAT     = 12'h178;
    localparam logic [2:0]  BANK_PORT     = 3'h2;
    localparam logic [2:0]  BANK_RESET    = 3'h0;
    // Field positions and reset values.
    localparam int          CMD_EN_BIT    = 0;
    localparam int          PC_IP_CHK     = 4;
    localparam int          PC_MAC_CHK    = 3;
    localparam int          PC_L2_DET     = 2;
    localparam int          PC_V6_DET     = 1;
    localparam int          PC_V4_DET     = 0;
    localparam logic [4:0]  PARSE_RESET   = 5'h1f;
    localparam int          QC_DOMAIN_LSB = 24;
    localparam int          QC_DOMAIN_EN  = 23;
    localparam int          QC_ALT_CHK    = 22;
    localparam int          QC_UDP_BYP    = 21;
    localparam int          QC_FCS_BYP    = 20;
    localparam int          QC_VER_LSB    = 16;
    localparam int          QC_MASK_LSB   = 0;
    localparam logic [31:0] QUAL_RESET    = 32'h0002_0000;
    localparam int          STAT_POP_BIT  = 0;
    localparam int          STAT_OVF_BIT  = 8;
    // Frame layout.
    localparam int          HDR_LEN       = 76;
    localparam logic [15:0] ETH_L2        = 16'h88f7;
    localparam logic [15:0] ETH_V4        = 16'h0800;
    localparam logic [15:0] ETH_V6        = 16'h86dd;
    localparam logic [7:0]  V4_VER_IHL    = 8'h45;
    localparam logic [7:0]  IP_UDP        = 8'h11;
    localparam logic [15:0] PORT_EVENT    = 16'h013f;
    localparam logic [15:0] PORT_GENERAL  = 16'h0140;
    localparam logic [6:0]  OFS_ETYPE     = 7'h0c;
    localparam logic [6:0]  OFS_V4_VER    = 7'h0e;
    localparam logic [6:0]  OFS_V4_PROTO  = 7'h17;
    localparam logic [6:0]  OFS_V4_DIP    = 7'h1e;
    localparam logic [6:0]  OFS_V4_DPORT  = 7'h24;
    localparam logic [6:0]  OFS_V6_NXT    = 7'h14;
    localparam logic [6:0]  OFS_V6_DIP    = 7'h26;
    localparam logic [6:0]  OFS_V6_DPORT  = 7'h38;
    localparam logic [6:0]  OFS_L2_PTP    = 7'h0e;
    localparam logic [6:0]  OFS_V4_PTP    = 7'h2a;
    localparam logic [6:0]  OFS_V6_PTP    = 7'h3e;
    localparam logic [6:0]  PTP_VER       = 7'h01;
    localparam logic [6:0]  PTP_DOMAIN    = 7'h04;
    localparam logic [6:0]  PTP_FLAGS     = 7'h06;
    // Destination addresses accepted by the address checks.
    localparam logic [47:0] MAC_L2_A      = 48'h011b_1900_0000;
    localparam logic [47:0] MAC_L2_B      = 48'h0180_c200_000e;
    localparam logic [47:0] MAC_V4        = 48'h0100_5e00_0181;
    localparam logic [47:0] MAC_V6        = 48'h3333_0000_0181;
    localparam logic [31:0] IP4_DEST      = 32'he000_0181;
    localparam logic [11:0] IP6_DEST_HI   = 12'hff0;
    localparam logic [111:0] IP6_DEST_LO  = 112'h181;
endpackage : tx_ptp_qual_pkg

// *** rtl/ptp_dest_matcher.sv ***
// Destination MAC and IP comparison for the transmit PTP qualifier.
// Purely combinational; the caller registers whatever it derives from it.
module ptp_dest_matcher (
    input  wire logic         i_fmt_l2,
    input  wire logic         i_fmt_v4,
    input  wire logic         i_fmt_v6,
    input  wire logic [47:0]  i_dest_mac,
    input  wire logic [31:0]  i_dest_ip4,
    input  wire logic [127:0] i_dest_ip6,
    output logic              o_mac_hit,
    output logic              o_ip_hit
);
    import tx_ptp_qual_pkg::*;

    // The IPv6 scope nibble is a wildcard so every scope of the group matches.
    always_comb begin
        o_mac_hit = (i_fmt_l2 && (i_dest_mac == MAC_L2_A || i_dest_mac == MAC_L2_B))
                 || (i_fmt_v4 && i_dest_mac == MAC_V4)
                 || (i_fmt_v6 && i_dest_mac == MAC_V6);
        o_ip_hit  = (i_fmt_v4 && i_dest_ip4 == IP4_DEST)
                 || (i_fmt_v6 && i_dest_ip6[127:116] == IP6_DEST_HI
                              && i_dest_ip6[111:0] == IP6_DEST_LO);
    end
endmodule : ptp_dest_matcher

// *** rtl/ts_capture_fifo.sv ***
// Small first-in first-out store for qualified egress timestamps.
// Push and pop come from the same clock; a push while full is refused.
module ts_capture_fifo #(
    parameter int WIDTH = 94,
    parameter int DEPTH = 4,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_srst,
    input  wire logic             i_push,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_pop,
    output logic      [WIDTH-1:0] o_head,
    output logic      [CNT_W-1:0] o_count,
    output logic                  o_full
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] rd_r;
    logic [PTR_W-1:0] rd_nxt;
    logic [PTR_W-1:0] wr_r;
    logic [PTR_W-1:0] wr_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             do_push;
    logic             do_pop;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    always_comb begin
        do_pop  = i_pop && (cnt_r != '0);
        do_push = i_push && (cnt_r != CNT_W'(DEPTH));
        rd_nxt  = do_pop ? ptr_inc(rd_r) : rd_r;
        wr_nxt  = do_push ? ptr_inc(wr_r) : wr_r;
        cnt_nxt = cnt_r + CNT_W'(do_push) - CNT_W'(do_pop);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rd_r  <= '0;
            wr_r  <= '0;
            cnt_r <= '0;
        end else begin
            rd_r  <= rd_nxt;
            wr_r  <= wr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (do_push) begin
            mem[wr_r] <= i_data;
        end
    end

    assign o_head  = mem[rd_r];
    assign o_count = cnt_r;
    assign o_full  = (cnt_r == CNT_W'(DEPTH));
endmodule : ts_capture_fifo

// *** rtl/tx_ptp_timestamp_qualifier.sv ***
// Transmit PTP timestamp qualifier: parses outgoing frames, applies the
// configured filters and buffers the egress time of qualified messages.
// Assumes a byte stream from the MAC transmit path on i_sys_clk and an APB3
// master on the same clock.
// What this block does
// - IP destination check bit 4 resets set; checks IPv4 and IPv6 destination.
// - MAC destination check bit 3 resets set; checks destination MAC address.
// - Layer 2 detect bit 2 resets set; recognises Ethernet-carried PTP.
// - IPv6 detect bit 1 resets set; recognises UDP over IPv6 PTP.
// - IPv4 detect bit 0 resets set; recognises UDP over IPv4 PTP.
// - Domain field bits 31:24 reset 0; must equal domainNumber when matching.
// - Bit 23 reset 0 enables domain comparison; clear means domain ignored.
// - Bit 22 reset 0 requires alternateMasterFlag zero to qualify.
// - Bit 21 clear rejects bad UDP checksum; set bypasses the check.
// - Bit 20 clear rejects bad FCS; set bypasses the check.
// - Version field bits 19:16 reset 2; zero accepts any version.
// - Mask bits 15:0 reset 0; bit n enables messageType n.
// - Qualified egress times go to a four-entry buffer for software.
module tx_ptp_timestamp_qualifier #(
    parameter int TS_DEPTH = 4
) (
    input  wire logic                                i_sys_clk,
    input  wire logic                                i_srst,
    input  wire logic                                i_psel,
    input  wire logic                                i_penable,
    input  wire logic                                i_pwrite,
    input  wire logic [tx_ptp_qual_pkg::APB_AW-1:0]  i_paddr,
    input  wire logic [tx_ptp_qual_pkg::APB_DW-1:0]  i_pwdata,
    output logic      [tx_ptp_qual_pkg::APB_DW-1:0]  o_prdata,
    output logic                                     o_pready,
    output logic                                     o_pslverr,
    input  wire logic                                i_tx_valid,
    input  wire logic [7:0]                          i_tx_data,
    input  wire logic                                i_tx_last,
    input  wire logic                                i_tx_fcs_bad,
    input  wire logic                                i_tx_udp_sum_bad,
    input  wire logic [31:0]                         i_egress_sec,
    input  wire logic [29:0]                         i_egress_ns,
    output logic                                     o_ts_qualified
);
    import tx_ptp_qual_pkg::*;

    localparam int CNT_W  = $clog2(TS_DEPTH + 1);
    localparam int ENTRY_W = 32 + 30 + 32;

    typedef enum logic [1:0] {ST_IDLE, ST_BODY, ST_EVAL} frame_state_e;

    // Configuration and status registers.
    logic              cmd_en_r,  cmd_en_nxt;
    logic [2:0]        bank_r,    bank_nxt;
    logic [4:0]        parse_r,   parse_nxt;
    logic [31:0]       qual_r,    qual_nxt;
    logic              ovf_r,     ovf_nxt;
    logic [31:0]       prdata_r,  prdata_nxt;
    logic              pready_r,  pready_nxt;
    logic              pslverr_r, pslverr_nxt;
    logic              qual_out_r;
    // Frame capture.
    frame_state_e      st_r,      st_nxt;
    logic [6:0]        cnt_r,     cnt_nxt;
    logic [31:0]       sec_r,     sec_nxt;
    logic [29:0]       ns_r,      ns_nxt;
    logic              fcs_bad_r, fcs_bad_nxt;
    logic              udp_bad_r, udp_bad_nxt;
    logic [7:0]        hdr [HDR_LEN];
    logic              hdr_we;
    logic [6:0]        hdr_idx;
    // Evaluation.
    logic              eval_now;
    logic [15:0]       etype;
    logic              fmt_l2, fmt_v4, fmt_v6, fmt_any;
    logic [6:0]        base;
    logic [3:0]        msg_type;
    logic [3:0]        msg_ver;
    logic [7:0]        msg_domain;
    logic [7:0]        msg_flag0, msg_flag1;
    logic [47:0]       dest_mac;
    logic [31:0]       dest_ip4;
    logic [127:0]      dest_ip6;
    logic              mac_hit, ip_hit;
    logic              mac_ok, ip_ok, dom_ok, alt_ok, ver_ok, type_ok, fcs_ok, udp_ok;
    logic              all_ok, qual_now;
    // Buffer and bus.
    logic [ENTRY_W-1:0] head;
    logic [CNT_W-1:0]   ts_count;
    logic               ts_full;
    logic               ts_pop;
    logic               port_bank;
    logic               wr_fire;

    function automatic logic port_ok(input logic [15:0] p);
        port_ok = (p == PORT_EVENT) || (p == PORT_GENERAL);
    endfunction : port_ok

    // Frame capture: the last byte leads to one evaluation cycle, during which
    // a new frame may already begin because writes land only at the edge.
    always_comb begin
        st_nxt      = st_r;
        cnt_nxt     = cnt_r;
        sec_nxt     = sec_r;
        ns_nxt      = ns_r;
        fcs_bad_nxt = fcs_bad_r;
        udp_bad_nxt = udp_bad_r;
        hdr_idx     = (st_r == ST_BODY) ? cnt_r : 7'h00;
        hdr_we      = i_tx_valid && (hdr_idx < 7'(HDR_LEN));
        case (st_r)
            ST_IDLE, ST_EVAL: begin
                st_nxt = ST_IDLE;
                if (i_tx_valid) begin
                    sec_nxt = i_egress_sec;
                    ns_nxt  = i_egress_ns;
                    cnt_nxt = 7'h01;
                    st_nxt  = i_tx_last ? ST_EVAL : ST_BODY;
                end
            end
            ST_BODY: begin
                if (i_tx_valid) begin
                    cnt_nxt = (cnt_r == 7'h7f) ? cnt_r : cnt_r + 7'h01;
                    if (i_tx_last) begin
                        st_nxt = ST_EVAL;
                    end
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        if (i_tx_valid && i_tx_last) begin
            fcs_bad_nxt = i_tx_fcs_bad;
            udp_bad_nxt = i_tx_udp_sum_bad;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st_r      <= ST_IDLE;
            cnt_r     <= 7'h00;
            sec_r     <= 32'h0;
            ns_r      <= 30'h0;
            fcs_bad_r <= 1'b0;
            udp_bad_r <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            cnt_r     <= cnt_nxt;
            sec_r     <= sec_nxt;
            ns_r      <= ns_nxt;
            fcs_bad_r <= fcs_bad_nxt;
            udp_bad_r <= udp_bad_nxt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (hdr_we) begin
            hdr[hdr_idx] <= i_tx_data;
        end
    end

    // Format detection, field extraction and the filter chain.
    always_comb begin
        eval_now = (st_r == ST_EVAL);
        etype    = {hdr[OFS_ETYPE], hdr[OFS_ETYPE + 7'h01]};
        fmt_l2   = parse_r[PC_L2_DET] && etype == ETH_L2;
        fmt_v4   = parse_r[PC_V4_DET] && etype == ETH_V4 && hdr[OFS_V4_VER] == V4_VER_IHL
                && hdr[OFS_V4_PROTO] == IP_UDP
                && port_ok({hdr[OFS_V4_DPORT], hdr[OFS_V4_DPORT + 7'h01]});
        fmt_v6   = parse_r[PC_V6_DET] && etype == ETH_V6 && hdr[OFS_V6_NXT] == IP_UDP
                && port_ok({hdr[OFS_V6_DPORT], hdr[OFS_V6_DPORT + 7'h01]});
        fmt_any  = fmt_l2 || fmt_v4 || fmt_v6;
        base     = fmt_l2 ? OFS_L2_PTP : (fmt_v4 ? OFS_V4_PTP : OFS_V6_PTP);
        msg_type   = hdr[base][3:0];
        msg_ver    = hdr[base + PTP_VER][3:0];
        msg_domain = hdr[base + PTP_DOMAIN];
        msg_flag0  = hdr[base + PTP_FLAGS];
        msg_flag1  = hdr[base + PTP_FLAGS + 7'h01];
        for (int i = 0; i < 6; i++) begin
            dest_mac[47 - 8 * i -: 8] = hdr[i];
        end
        for (int i = 0; i < 4; i++) begin
            dest_ip4[31 - 8 * i -: 8] = hdr[OFS_V4_DIP + 7'(i)];
        end
        for (int i = 0; i < 16; i++) begin
            dest_ip6[127 - 8 * i -: 8] = hdr[OFS_V6_DIP + 7'(i)];
        end
    end

    ptp_dest_matcher u_dest_matcher (
        .i_fmt_l2   (fmt_l2),
        .i_fmt_v4   (fmt_v4),
        .i_fmt_v6   (fmt_v6),
        .i_dest_mac (dest_mac),
        .i_dest_ip4 (dest_ip4),
        .i_dest_ip6 (dest_ip6),
        .o_mac_hit  (mac_hit),
        .o_ip_hit   (ip_hit)
    );

    // Layer 2 frames carry no IP header, so the IP check passes for them.
    always_comb begin
        mac_ok  = !parse_r[PC_MAC_CHK] || mac_hit;
        ip_ok   = !parse_r[PC_IP_CHK] || fmt_l2 || ip_hit;
        dom_ok  = !qual_r[QC_DOMAIN_EN]
               || msg_domain == qual_r[QC_DOMAIN_LSB +: 8];
        alt_ok  = !qual_r[QC_ALT_CHK] || !msg_flag0[0];
        ver_ok  = qual_r[QC_VER_LSB +: 4] == 4'h0
               || msg_ver == qual_r[QC_VER_LSB +: 4];
        type_ok = qual_r[QC_MASK_LSB + 32'(msg_type)];
        fcs_ok  = qual_r[QC_FCS_BYP] || !fcs_bad_r;
        udp_ok  = qual_r[QC_UDP_BYP] || fmt_l2 || !udp_bad_r;
        all_ok  = fmt_any && mac_ok && ip_ok && dom_ok && alt_ok
               && ver_ok && type_ok && fcs_ok && udp_ok;
        qual_now = eval_now && cmd_en_r && all_ok;
    end

    ts_capture_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (TS_DEPTH),
        .CNT_W (CNT_W)
    ) u_ts_fifo (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_push    (qual_now),
        .i_data    ({sec_r, ns_r, msg_type, msg_ver, msg_domain, msg_flag0, msg_flag1}),
        .i_pop     (ts_pop),
        .o_head    (head),
        .o_count   (ts_count),
        .o_full    (ts_full)
    );

    // APB slave: one access cycle, the answer is prepared in the setup cycle.
    // Banked port registers answer only while bank 2 is selected.
    always_comb begin
        port_bank   = (bank_r == BANK_PORT);
        wr_fire     = i_psel && i_penable && pready_r && i_pwrite && !pslverr_r;
        cmd_en_nxt  = cmd_en_r;
        bank_nxt    = bank_r;
        parse_nxt   = parse_r;
        qual_nxt    = qual_r;
        ts_pop      = 1'b0;
        pready_nxt  = i_psel && !i_penable;
        pslverr_nxt = 1'b0;
        prdata_nxt  = 32'h0;
        case (i_paddr)
            ADDR_CMD:    prdata_nxt = {31'h0, cmd_en_r};
            ADDR_BANK:   prdata_nxt = {29'h0, bank_r};
            ADDR_PARSE:  prdata_nxt = {27'h0, parse_r};
            ADDR_QUAL:   prdata_nxt = qual_r;
            ADDR_EG_SEC: prdata_nxt = head[ENTRY_W-1 -: 32];
            ADDR_EG_NS:  prdata_nxt = {2'b00, head[61:32]};
            ADDR_HDR:    prdata_nxt = head[31:0];
            ADDR_STAT:   prdata_nxt = {23'h0, ovf_r, {(8 - CNT_W){1'b0}}, ts_count};
            default:     pslverr_nxt = pready_nxt;
        endcase
        if (i_paddr >= ADDR_PARSE && !port_bank) begin
            prdata_nxt  = 32'h0;
            pslverr_nxt = pready_nxt;
        end
        if (i_pwrite) begin
            prdata_nxt = 32'h0;
        end
        if (wr_fire) begin
            case (i_paddr)
                ADDR_CMD:   cmd_en_nxt = i_pwdata[CMD_EN_BIT];
                ADDR_BANK:  bank_nxt   = i_pwdata[2:0];
                ADDR_PARSE: parse_nxt  = i_pwdata[4:0];
                ADDR_QUAL:  qual_nxt   = i_pwdata;
                ADDR_STAT:  ts_pop     = i_pwdata[STAT_POP_BIT];
                default:    ts_pop     = 1'b0;
            endcase
        end
        // A refused push in the same cycle as the clear keeps the flag set.
        ovf_nxt = (qual_now && ts_full)
               || (ovf_r && !(wr_fire && i_paddr == ADDR_STAT && i_pwdata[STAT_OVF_BIT]));
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            cmd_en_r   <= 1'b0;
            bank_r     <= BANK_RESET;
            parse_r    <= PARSE_RESET;
            qual_r     <= QUAL_RESET;
            ovf_r      <= 1'b0;
            prdata_r   <= 32'h0;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            qual_out_r <= 1'b0;
        end else begin
            cmd_en_r   <= cmd_en_nxt;
            bank_r     <= bank_nxt;
            parse_r    <= parse_nxt;
            qual_r     <= qual_nxt;
            ovf_r      <= ovf_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            qual_out_r <= qual_now;
        end
    end

    assign o_prdata       = prdata_r;
    assign o_pready       = pready_r;
    assign o_pslverr      = pslverr_r;
    assign o_ts_qualified = qual_out_r;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    AST_IP_CHECK: assert property (eval_now && parse_r[PC_IP_CHK] && !fmt_l2 && !ip_hit
        |=> !o_ts_qualified) else $error("IP destination miss still qualified");
    AST_MAC_CHECK: assert property (eval_now && parse_r[PC_MAC_CHK] && !mac_hit
        |=> !o_ts_qualified) else $error("MAC destination miss still qualified");
    AST_L2_OFF: assert property (eval_now && !parse_r[PC_L2_DET] && etype == ETH_L2
        |=> !o_ts_qualified) else $error("Layer 2 frame qualified while detection off");
    AST_V6_OFF: assert property (eval_now && !parse_r[PC_V6_DET] && etype == ETH_V6
        |=> !o_ts_qualified) else $error("IPv6 frame qualified while detection off");
    AST_V4_OFF: assert property (eval_now && !parse_r[PC_V4_DET] && etype == ETH_V4
        |=> !o_ts_qualified) else $error("IPv4 frame qualified while detection off");
    AST_DOMAIN: assert property (o_ts_qualified && $past(qual_r[QC_DOMAIN_EN])
        |-> $past(msg_domain) == $past(qual_r[31:24]))
        else $error("Domain mismatch qualified");
    AST_ALT: assert property (o_ts_qualified && $past(qual_r[QC_ALT_CHK])
        |-> !$past(msg_flag0[0])) else $error("Alternate master message qualified");
    AST_UDP: assert property (eval_now && !qual_r[QC_UDP_BYP] && udp_bad_r && !fmt_l2
        |=> !o_ts_qualified) else $error("Bad UDP checksum qualified");
    AST_FCS: assert property (eval_now && !qual_r[QC_FCS_BYP] && fcs_bad_r
        |=> !o_ts_qualified) else $error("Bad FCS qualified");
    AST_VER: assert property (o_ts_qualified && $past(qual_r[19:16]) != 4'h0
        |-> $past(msg_ver) == $past(qual_r[19:16])) else $error("Wrong version qualified");
    AST_MASK: assert property (o_ts_qualified
        |-> $past(qual_r[QC_MASK_LSB + 32'(msg_type)])) else $error("Masked type qualified");
    AST_PUSH: assert property (qual_now && !ts_full && !ts_pop
        |=> ts_count == $past(ts_count) + 1'b1) else $error("Qualified time not buffered");
    AST_ALL: assert property (o_ts_qualified |-> $past(all_ok && cmd_en_r))
        else $error("Qualified without every check passing");

    COV_QUALIFIED: cover property (o_ts_qualified);
    COV_FULL: cover property (ts_full && qual_now);
    COV_POP: cover property (ts_pop ##1 ts_count != '0);
    COV_V6: cover property (eval_now && fmt_v6 && all_ok);
endmodule : tx_ptp_timestamp_qualifier

// *** sim/tx_mac_model.sv ***
// Behavioural model of the MAC transmit path that feeds the qualifier.
// Assumes send is entered just after a rising edge of i_sys_clk.
module tx_mac_model (
    input  wire logic        i_sys_clk,
    output logic             o_valid,
    output logic [7:0]       o_data,
    output logic             o_last,
    output logic             o_fcs_bad,
    output logic             o_udp_bad,
    output logic [31:0]      o_sec,
    output logic [29:0]      o_ns
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] frame_q[$];
    initial begin
        {o_valid, o_last, o_fcs_bad, o_udp_bad, o_data, o_sec, o_ns} = '0;
    end
    task automatic send(input logic fcs_bad, input logic udp_bad);
        for (int i = 0; i < frame_q.size(); i++) begin
            o_valid <= 1'b1;
            o_data <= frame_q[i];
            o_last <= (i == frame_q.size() - 1);
            o_fcs_bad <= fcs_bad;
            o_udp_bad <= udp_bad;
            if (i == 0) o_sec <= $urandom;
            if (i == 0) o_ns <= 30'($urandom);
            @(posedge i_sys_clk);
        end
        o_valid <= 1'b0;
        o_last <= 1'b0;
        // Idle data is scrambled so a stale byte can never pass as a valid one.
        o_data <= ~o_data;
    endtask : send
endmodule : tx_mac_model

// *** sim/test_tx_ptp_timestamp_qualifier.sv ***
// Self-checking bench: APB master, MAC model and a reference qualifier model.
// Assumes rtl/tx_ptp_qual_pkg.sv and sim/tx_mac_model.sv are compiled first.
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: %s", $time, m); end end
module test_tx_ptp_timestamp_qualifier import tx_ptp_qual_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, rdy, err, v, l, fb, ub, q, e;
    logic [11:0] addr = '0;
    logic [31:0] wd = '0, rd, sec, r;
    logic [7:0]  d;
    logic [29:0] ns;
    int          fail_count = 0, compares = 0;
    always #5 clk = ~clk;
    tx_mac_model mac (.i_sys_clk(clk), .o_valid(v), .o_data(d), .o_last(l), .o_fcs_bad(fb),
        .o_udp_bad(ub), .o_sec(sec), .o_ns(ns));
    tx_ptp_timestamp_qualifier dut (.i_sys_clk(clk), .i_srst(srst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_prdata(rd),
        .o_pready(rdy), .o_pslverr(err), .i_tx_valid(v), .i_tx_data(d), .i_tx_last(l),
        .i_tx_fcs_bad(fb), .i_tx_udp_sum_bad(ub), .i_egress_sec(sec), .i_egress_ns(ns),
        .o_ts_qualified(q));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] x);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= x;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        if (rdy !== 1'b1) fail_count++;
        r = rd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic end_of_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // Writes n bytes of x into the pending frame, most significant byte first.
    task automatic put(input int at, input int n, input logic [47:0] x);
        for (int i = 0; i < n; i++) mac.frame_q[at + i] = x[8 * (n - 1 - i) +: 8];
    endtask : put
    initial begin
        logic [15:0]  mask;
        logic [7:0]   dom, md;
        logic [3:0]   ver, mv, ty, qb;
        logic [4:0]   pc;
        int           b;
        logic         gi, ubd, v4;
        logic [31:0]  sq[$];
        logic         good, fl, fbad, exp;
        r = $urandom(84);
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        apb(1'b0, ADDR_QUAL, '0);
        `CHK(e, 1'b1, "banked read before bank select")
        apb(1'b1, ADDR_BANK, 32'h2);
        apb(1'b0, ADDR_QUAL, '0);
        `CHK(r, 32'h0002_0000, "qual config reset")
        apb(1'b0, ADDR_PARSE, '0);
        `CHK(r[4:0], 5'h1f, "parse config reset")
        $display("register test done");
        for (int k = 0; k < 40; k++) begin
            {mask, ty, qb, pc, good, fl, fbad} = $urandom;
            if (k[0]) mask[3:0] = 4'hf;
            dom = 8'($urandom % 2);
            md = 8'($urandom % 2);
            ver = 4'(($urandom % 2) * 2);
            mv = 4'(2 + $urandom % 2);
            // Settings change only while the unit is disabled.
            apb(1'b1, ADDR_CMD, 32'h0);
            apb(1'b1, ADDR_PARSE, {27'h0, pc});
            apb(1'b1, ADDR_QUAL, {dom, qb, ver, mask});
            apb(1'b1, ADDR_CMD, 32'h1);
            {gi, ubd, v4} = 3'($urandom);
            mac.frame_q = {};
            for (int i = 0; i < HDR_LEN; i++)
                mac.frame_q.push_back(8'($urandom));
            b = v4 ? 42 : 14;
            put(0, 6, (v4 ? MAC_V4 : MAC_L2_A) ^ 48'(!good));
            put(12, 2, 48'(v4 ? ETH_V4 : ETH_L2));
            if (v4) begin
                put(14, 1, 48'(V4_VER_IHL));
                put(23, 1, 48'(IP_UDP));
                put(30, 4, 48'(IP4_DEST ^ 32'(!gi)));
                put(36, 2, 48'(PORT_EVENT + 16'(fl)));
            end
            mac.frame_q[b] = {4'($urandom), ty};
            mac.frame_q[b + 1] = {4'($urandom), mv};
            mac.frame_q[b + 4] = md;
            mac.frame_q[b + 6] = {7'($urandom), fl};
            exp = v4 ? pc[0] && (!pc[4] || gi) && (qb[1] || !ubd) : pc[2];
            exp = exp && (!pc[3] || good) && (!qb[3] || dom == md) && (!qb[2] || !fl)
                && (qb[0] || !fbad) && (ver == 0 || ver == mv) && mask[ty];
            mac.send(fbad, ubd);
            if (exp) sq.push_back(sec);
            @(posedge clk);
            #1;
            `CHK(q, exp, "qualify pulse")
            @(posedge clk);
        end
        apb(1'b0, ADDR_STAT, '0);
        `CHK(r[2:0], 3'(sq.size() > 4 ? 4 : sq.size()), "buffer count")
        `CHK(r[8], sq.size() > 4, "buffer overflow")
        for (int i = 0; i < 2 && i < sq.size(); i++) begin
            apb(1'b0, ADDR_EG_SEC, '0);
            `CHK(r, sq[i], "buffered seconds")
            apb(1'b1, ADDR_STAT, 32'h1);
        end
        $display("frame test done");
        end_of_test();
    end
    initial begin
        #500us;
        fail_count++;
        end_of_test();
    end
endmodule : test_tx_ptp_timestamp_qualifier
